// ---- inc/cbi_pkg.sv ----
// Package for the processor system bus interface: constants and enums
//
// Contract
// - Drive 16-bit address of each access; refresh address during refresh.
// - During external master access to on-chip peripherals, address lines are inputs.
// - Data lines bidirectional; driven while processor accesses an on-chip peripheral; here driven only during processor write cycles.
// - Read strobe asserted for processor reads; input during external master access.
// - Write strobe asserted while write data valid; input during external access.
// - Memory request low while memory address valid; floated during external access.
// - I/O request low with port address on low eight lines; input externally.
// - Interrupt acknowledge asserts I/O request together with first-cycle strobe.
// - Every opcode fetch, including each byte of two-byte opcodes, asserts first-cycle.
// - Maskable acknowledge pairs first-cycle with I/O request, never memory request.
// - Evaluation mode floats the first-cycle strobe.
package cbi_pkg;
   // Cycle kinds requested by the processor core
   typedef enum logic [2:0] {
      CBI_OP_FETCH,
      CBI_OP_MEMRD,
      CBI_OP_MEMWR,
      CBI_OP_IORD,
      CBI_OP_IOWR,
      CBI_OP_INTACK,
      CBI_OP_REFRESH
   } cbi_op_t;

   // Bus sequencer states
   typedef enum logic [2:0] {
      CBI_IDLE,
      CBI_ADDR,
      CBI_STROBE,
      CBI_REFR,
      CBI_END,
      CBI_RELEASED
   } cbi_state_t;

   localparam int CBI_ADDR_W       = 16;
   localparam int CBI_DATA_W       = 8;
   localparam int CBI_PORT_W       = 8;
   localparam int CBI_STROBE_CYCLES = 2;
   localparam logic [15:0] CBI_ADDR_RST = 16'h0000;
   localparam logic [7:0]  CBI_DATA_RST = 8'h00;
endpackage : cbi_pkg

// ---- design/cbi_strobe_enc.sv ----
// Strobe encoder: maps a cycle kind and phase to the active-low strobes
`timescale 1ns/1ps
`default_nettype none
module cbi_strobe_enc
   import cbi_pkg::*;
(
   // Cycle request
   input  wire cbi_op_t op,
   input  wire logic    strobePhase,
   input  wire logic    addrPhase,
   // Encoded strobes, active low
   output logic         memReqN,
   output logic         ioReqN,
   output logic         firstCycleN,
   output logic         readN,
   output logic         writeN
);
   wire isFetch = (op == CBI_OP_FETCH);
   wire isMem   = isFetch || (op == CBI_OP_MEMRD) || (op == CBI_OP_MEMWR)
                  || (op == CBI_OP_REFRESH);
   wire isIo    = (op == CBI_OP_IORD) || (op == CBI_OP_IOWR);
   wire isAck   = (op == CBI_OP_INTACK);
   wire isRead  = isFetch || (op == CBI_OP_MEMRD) || (op == CBI_OP_IORD);
   wire isWrite = (op == CBI_OP_MEMWR) || (op == CBI_OP_IOWR);

   // Memory request covers address and strobe phases; never in acknowledge
   assign memReqN     = ~(isMem && (addrPhase || strobePhase));
   // I/O request for port cycles and for the acknowledge
   assign ioReqN      = ~((isIo || isAck) && strobePhase);
   // First-cycle strobe on fetch and acknowledge only
   assign firstCycleN = ~((isFetch || isAck) && (addrPhase || strobePhase));
   assign readN       = ~(isRead && strobePhase);
   assign writeN      = ~(isWrite && strobePhase);
endmodule // cbi_strobe_enc
`default_nettype wire

// ---- design/cbi_bus_if.sv ----
// Processor system bus interface: address, data and control pin drivers
`timescale 1ns/1ps
`default_nettype none
module cbi_bus_if
   import cbi_pkg::*;
#(
   parameter int ADDR_W = 16,
   parameter int DATA_W = 8
)(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // Processor core request side
   input  wire logic              cycleReq,
   input  wire cbi_op_t           cycleOp,
   input  wire logic [ADDR_W-1:0] cycleAddr,
   input  wire logic [DATA_W-1:0] cycleWrData,
   input  wire logic [ADDR_W-1:0] refreshAddr,
   input  wire logic              busReleaseReq,
   input  wire logic              evaluation_mode,
   output logic                   cycleDone,
   output logic [DATA_W-1:0]      cycleRdData,
   output logic                   busReleased,
   // Address lines
   input  wire logic [ADDR_W-1:0] addrLinesIn,
   output logic [ADDR_W-1:0]      addrLinesOut,
   output logic                   addrLinesOeN,
   // Data lines
   input  wire logic [DATA_W-1:0] dataLinesIn,
   output logic [DATA_W-1:0]      dataLinesOut,
   output logic                   dataLinesOeN,
   // Strobes: value and enable, enable low while driving
   input  wire logic              readNIn,
   input  wire logic              writeNIn,
   input  wire logic              ioRequestNIn,
   output logic                   readNOut,
   output logic                   writeNOut,
   output logic                   memRequestNOut,
   output logic                   ioRequestNOut,
   output logic                   firstCycleNOut,
   output logic                   ctrlOeN,
   output logic                   memRequestOeN,
   output logic                   firstCycleOeN,
   // External master view toward on-chip peripherals
   output logic [ADDR_W-1:0]      extAddr_ff,
   output logic                   extRead_ff,
   output logic                   extWrite_ff,
   output logic                   extIoReq_ff
);
   // Widths are fixed by the pin count; refuse anything else at elaboration
   if (ADDR_W != CBI_ADDR_W || DATA_W != CBI_DATA_W) begin : g_bad_width
      $error("cbi_bus_if: bus widths fixed at 16 address and 8 data bits");
   end

   cbi_state_t state_ff, nxtState;
   cbi_op_t    op_ff;
   logic [ADDR_W-1:0] addr_ff;
   logic [DATA_W-1:0] wrData_ff;
   logic [1:0]        cnt_ff;
   logic memN, ioN, m1N, rdN, wrN;

   // Sequencer phase decode
   wire inAddr    = (state_ff == CBI_ADDR);
   wire inStrobe  = (state_ff == CBI_STROBE);
   wire inRefr    = (state_ff == CBI_REFR);
   wire released  = (state_ff == CBI_RELEASED);
   wire isWrOp    = (op_ff == CBI_OP_MEMWR) || (op_ff == CBI_OP_IOWR);
   wire strobeEnd = (cnt_ff == 2'(CBI_STROBE_CYCLES - 1));

   cbi_strobe_enc u_enc (
      .op          (op_ff),
      .strobePhase (inStrobe || inRefr),
      .addrPhase   (inAddr),
      .memReqN     (memN),
      .ioReqN      (ioN),
      .firstCycleN (m1N),
      .readN       (rdN),
      .writeN      (wrN)
   );

   // Next state; release only from idle so no cycle is cut short
   always_comb begin
      nxtState = state_ff;
      unique case (state_ff)
         CBI_IDLE:     if (busReleaseReq) nxtState = CBI_RELEASED;
                       else if (cycleReq) nxtState = CBI_ADDR;
         CBI_ADDR:     nxtState = (op_ff == CBI_OP_REFRESH) ? CBI_REFR : CBI_STROBE;
         CBI_STROBE:   if (strobeEnd) nxtState = CBI_END;
         CBI_REFR:     if (strobeEnd) nxtState = CBI_END;
         CBI_END:      nxtState = CBI_IDLE;
         CBI_RELEASED: if (!busReleaseReq) nxtState = CBI_IDLE;
         default:      nxtState = CBI_IDLE; // Unused codes fall back to idle
      endcase
   end

   // Sequencer registers
   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff  <= CBI_IDLE;
         op_ff     <= CBI_OP_MEMRD;
         addr_ff   <= CBI_ADDR_RST;
         wrData_ff <= CBI_DATA_RST;
         cnt_ff    <= 2'h0;
      end else begin
         state_ff <= nxtState;
         cnt_ff   <= (inStrobe || inRefr) ? cnt_ff + 2'h1 : 2'h0;
         if (state_ff == CBI_IDLE && cycleReq && !busReleaseReq) begin
            op_ff     <= cycleOp;
            addr_ff   <= cycleAddr;
            wrData_ff <= cycleWrData;
         end
      end
   end

   // Pin outputs, all registered; I/O cycles carry port on the low byte
   wire [ADDR_W-1:0] portAddr = {{(ADDR_W-CBI_PORT_W){1'b0}}, addr_ff[CBI_PORT_W-1:0]};
   wire ioCyc = (op_ff == CBI_OP_IORD) || (op_ff == CBI_OP_IOWR);
   wire [ADDR_W-1:0] nxtAddrOut = (op_ff == CBI_OP_REFRESH) ? refreshAddr
                                : ioCyc ? portAddr : addr_ff;
   wire busy = inAddr || inStrobe || inRefr;
   always_ff @(posedge clk) begin
      if (rst) begin
         addrLinesOut   <= CBI_ADDR_RST;
         addrLinesOeN   <= 1'b0;
         dataLinesOut   <= CBI_DATA_RST;
         dataLinesOeN   <= 1'b1;
         readNOut       <= 1'b1;
         writeNOut      <= 1'b1;
         memRequestNOut <= 1'b1;
         ioRequestNOut  <= 1'b1;
         firstCycleNOut <= 1'b1;
         ctrlOeN        <= 1'b0;
         memRequestOeN  <= 1'b0;
         firstCycleOeN  <= 1'b0;
         busReleased    <= 1'b0;
      end else begin
         addrLinesOut   <= busy ? nxtAddrOut : addrLinesOut;
         addrLinesOeN   <= released;
         dataLinesOut   <= wrData_ff;
         dataLinesOeN   <= ~(busy && isWrOp);
         readNOut       <= released | rdN;
         writeNOut      <= released | wrN;
         memRequestNOut <= released | memN;
         ioRequestNOut  <= released | ioN;
         firstCycleNOut <= released | m1N;
         ctrlOeN        <= released;
         memRequestOeN  <= released;
         firstCycleOeN  <= evaluation_mode;
         busReleased    <= released;
      end
   end

   // Read capture and done pulse; external master inputs sampled when released
   always_ff @(posedge clk) begin
      if (rst) begin
         cycleDone   <= 1'b0;
         cycleRdData <= CBI_DATA_RST;
         extAddr_ff  <= CBI_ADDR_RST;
         extRead_ff  <= 1'b0;
         extWrite_ff <= 1'b0;
         extIoReq_ff <= 1'b0;
      end else begin
         cycleDone   <= inStrobe && strobeEnd || inRefr && strobeEnd;
         if (inStrobe && strobeEnd && !isWrOp)
            cycleRdData <= dataLinesIn;
         extAddr_ff  <= released ? addrLinesIn : extAddr_ff;
         extRead_ff  <= released && !readNIn;
         extWrite_ff <= released && !writeNIn;
         extIoReq_ff <= released && !ioRequestNIn;
      end
   end

   // Checks
   a_ack_pairs: assert property (@(posedge clk) disable iff (rst)
      (!ioRequestNOut && !firstCycleNOut) |-> memRequestNOut)
      else $error("acknowledge drove memory request");
   a_fetch_m1: assert property (@(posedge clk) disable iff (rst)
      (inStrobe && op_ff == CBI_OP_FETCH) |=> !firstCycleNOut && !memRequestNOut)
      else $error("fetch without first-cycle");
   a_ack_io: assert property (@(posedge clk) disable iff (rst)
      (inStrobe && op_ff == CBI_OP_INTACK) |=> !ioRequestNOut && !firstCycleNOut)
      else $error("acknowledge without io request");
   a_ev_float: assert property (@(posedge clk) disable iff (rst)
      evaluation_mode |=> firstCycleOeN)
      else $error("first-cycle driven in evaluation mode");
   a_release_safe: assert property (@(posedge clk) disable iff (rst)
      $rose(addrLinesOeN) |-> $past(state_ff) == CBI_RELEASED)
      else $error("pins turned while bus owned");
   a_released_float: assert property (@(posedge clk) disable iff (rst)
      busReleased |-> memRequestOeN && ctrlOeN && addrLinesOeN)
      else $error("strobe driven while released");
   a_refresh_addr: assert property (@(posedge clk) disable iff (rst)
      (inRefr && cnt_ff == 2'h0) |=> addrLinesOut == $past(refreshAddr, 2))
      else $error("refresh address missing");
   a_write_data: assert property (@(posedge clk) disable iff (rst)
      !writeNOut |-> !dataLinesOeN)
      else $error("write strobe without data");
   a_io_read: assert property (@(posedge clk) disable iff (rst)
      (inStrobe && op_ff == CBI_OP_IORD) |=> !readNOut && !ioRequestNOut)
      else $error("io read strobes missing");
   // Turnaround, port, contention, refresh and evaluation-mode checks
   a_io_port: assert property (@(posedge clk) disable iff (rst)
      (!ioRequestNOut && firstCycleNOut) |-> addrLinesOut[ADDR_W-1:CBI_PORT_W] == '0)
      else $error("io cycle without port on low byte");
   a_release_idle: assert property (@(posedge clk) disable iff (rst)
      $rose(busReleased) |-> $past(state_ff, 2) == CBI_IDLE)
      else $error("bus released in mid-cycle");
   a_read_float: assert property (@(posedge clk) disable iff (rst)
      !readNOut |-> dataLinesOeN)
      else $error("data lines driven during read");
   a_strobe_excl: assert property (@(posedge clk) disable iff (rst)
      readNOut || writeNOut)
      else $error("read and write strobes together");
   a_refresh_quiet: assert property (@(posedge clk) disable iff (rst)
      inRefr |=> readNOut && writeNOut && firstCycleNOut)
      else $error("refresh drove a data strobe");
   a_ev_drive: assert property (@(posedge clk) disable iff (rst)
      !evaluation_mode |=> !firstCycleOeN)
      else $error("first-cycle floated outside evaluation mode");
   c_fetch: cover property (@(posedge clk) inStrobe && op_ff == CBI_OP_FETCH);
   c_ack: cover property (@(posedge clk) inStrobe && op_ff == CBI_OP_INTACK);
   c_refresh: cover property (@(posedge clk) inRefr);
   c_release: cover property (@(posedge clk) busReleased && extWrite_ff);
   c_io_write: cover property (@(posedge clk) !ioRequestNOut && !writeNOut);
endmodule // cbi_bus_if
`default_nettype wire

// ---- sim/cbi_ext_mem.sv ----
// Far-side partner: external memory, I/O ports and acknowledge vector
`timescale 1ns/1ps
`default_nettype none
module cbi_ext_mem #(
   parameter logic [7:0] VECTOR = 8'h3c
)(
   // Clock
   input  wire logic        clk,
   // Bus as seen from outside
   input  wire logic [15:0] addr,
   input  wire logic [7:0]  dataIn,
   input  wire logic        readN,
   input  wire logic        writeN,
   input  wire logic        memReqN,
   input  wire logic        ioReqN,
   input  wire logic        firstN,
   // Data this side puts on the lines
   output logic [7:0]       dataOut
);
   logic [7:0] mem [16];
   logic [7:0] junk;
   logic       ack;
   initial begin
      junk = 8'h96;
      for (int i = 0; i < 16; i++) mem[i] = 8'h40 + 8'(i);
   end
   // Vector on acknowledge, else port or memory answer; junk when not read
   assign ack = !ioReqN && !firstN;
   assign dataOut = ack ? VECTOR : readN ? junk :
                    !ioReqN ? (addr[7:0] ^ 8'h5a) : mem[addr[3:0]];
   // Undriven lines change every cycle so a stale value never matches
   always @(posedge clk) begin
      junk <= ~junk + 8'h01;
      if (!writeN && !memReqN) begin
         mem[addr[3:0]] <= dataIn;
      end
   end
endmodule // cbi_ext_mem
`default_nettype wire

// ---- sim/cpu_system_bus_interface_bench.sv ----
// Self-checking bench for the processor system bus interface
`timescale 1ns/1ps
`default_nettype none
module cpu_system_bus_interface_bench import cbi_pkg::*;;
   logic clk, rst, cycleReq, busReleaseReq, evaluation_mode, cycleDone, busReleased;
   cbi_op_t cycleOp;
   logic [15:0] cycleAddr, refreshAddr, addrLinesIn, addrLinesOut, extAddr, aSeen, extAddr_ff;
   logic [7:0] cycleWrData, cycleRdData, dataLinesIn, dataLinesOut, farData;
   logic addrLinesOeN, dataLinesOeN, ctrlOeN, memRequestOeN, firstCycleOeN;
   logic readNOut, writeNOut, memRequestNOut, ioRequestNOut, firstCycleNOut;
   logic extRdN, extWrN, extIoN, extRead_ff, extWrite_ff, extIoReq_ff;
   logic sMem, sIo, sM1, sRd, sWr, dOk;
   int num_errors = 0;
   int n_checks = 0;
   // Resolve each shared line from whoever drives it
   assign addrLinesIn = addrLinesOeN ? extAddr : addrLinesOut;
   assign dataLinesIn = !dataLinesOeN ? dataLinesOut : farData;
   cbi_bus_if i_cbi_bus_if (.clk(clk), .rst(rst), .cycleReq(cycleReq), .cycleOp(cycleOp),
      .cycleAddr(cycleAddr), .cycleWrData(cycleWrData), .refreshAddr(refreshAddr),
      .busReleaseReq(busReleaseReq), .evaluation_mode(evaluation_mode),
      .cycleDone(cycleDone), .cycleRdData(cycleRdData), .busReleased(busReleased),
      .addrLinesIn(addrLinesIn), .addrLinesOut(addrLinesOut), .addrLinesOeN(addrLinesOeN),
      .dataLinesIn(dataLinesIn), .dataLinesOut(dataLinesOut), .dataLinesOeN(dataLinesOeN),
      .readNIn(ctrlOeN ? extRdN : readNOut), .writeNIn(ctrlOeN ? extWrN : writeNOut),
      .ioRequestNIn(ctrlOeN ? extIoN : ioRequestNOut), .readNOut(readNOut),
      .writeNOut(writeNOut), .memRequestNOut(memRequestNOut), .ioRequestNOut(ioRequestNOut),
      .firstCycleNOut(firstCycleNOut), .ctrlOeN(ctrlOeN), .memRequestOeN(memRequestOeN),
      .firstCycleOeN(firstCycleOeN), .extAddr_ff(extAddr_ff), .extRead_ff(extRead_ff),
      .extWrite_ff(extWrite_ff), .extIoReq_ff(extIoReq_ff));
   cbi_ext_mem i_cbi_ext_mem (.clk(clk), .addr(addrLinesOut), .dataIn(dataLinesOut),
      .readN(readNOut), .writeN(writeNOut), .memReqN(memRequestNOut),
      .ioReqN(ioRequestNOut), .firstN(firstCycleNOut), .dataOut(farData));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic report_and_stop();
      if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      n_checks++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask
   // One whole cycle; strobes seen low are gathered, write data judged live
   task automatic do_cycle(input cbi_op_t op, input logic [15:0] a, input logic [7:0] wd);
      int n;
      {sMem, sIo, sM1, sRd, sWr, dOk} = 6'b000001;
      n = 0;
      @(posedge clk);
      cycleOp <= op;
      {cycleReq, cycleAddr, cycleWrData} <= {1'b1, a, wd};
      @(posedge clk);
      cycleReq <= 1'b0;
      do begin
         @(posedge clk);
         #1;
         n++;
         sMem |= !memRequestNOut;
         sIo  |= !ioRequestNOut;
         sM1  |= !firstCycleNOut;
         sRd  |= !readNOut;
         sWr  |= !writeNOut;
         if (!(memRequestNOut && ioRequestNOut)) aSeen = addrLinesOut;
         if (!writeNOut) dOk &= (dataLinesOeN === 1'b0) && (dataLinesOut === wd);
      end while (cycleDone !== 1'b1 && n < 10);
      if (n >= 10) begin
         chk(1'b0, "cycle never finished");
         report_and_stop();
      end
   endtask
   task automatic t_mem();
      do_cycle(CBI_OP_FETCH, 16'h1234, 8'h00);
      chk(sMem && sM1 && sRd && !sIo && !sWr, "fetch strobes");
      chk(aSeen === 16'h1234 && cycleRdData === 8'h44, "fetch addr/data");
      do_cycle(CBI_OP_MEMWR, 16'hbee3, 8'ha7);
      chk(sMem && sWr && !sRd && !sM1 && dOk, "write strobes/data");
      do_cycle(CBI_OP_MEMRD, 16'h0003, 8'h00);
      chk(sRd && !sM1 && cycleRdData === 8'ha7, "read back");
   endtask
   task automatic t_io();
      do_cycle(CBI_OP_IOWR, 16'h12c5, 8'h3e);
      chk(sIo && !sMem && sWr && dOk && aSeen === 16'h00c5, "io write");
      do_cycle(CBI_OP_IORD, 16'h0081, 8'h00);
      chk(sIo && !sMem && cycleRdData === 8'hdb, "io read");
      do_cycle(CBI_OP_INTACK, 16'h0000, 8'h00);
      chk(sIo && sM1 && !sMem && cycleRdData === 8'h3c, "acknowledge");
      // Refresh address changes on a clock edge, well before the cycle
      @(posedge clk);
      refreshAddr <= 16'h007f;
      do_cycle(CBI_OP_REFRESH, 16'h0000, 8'h00);
      chk(sMem && !sRd && !sM1 && aSeen === 16'h007f, "refresh");
   endtask
   task automatic t_eval();
      @(posedge clk);
      evaluation_mode <= 1'b1;
      repeat (3) @(posedge clk);
      chk(firstCycleOeN === 1'b1, "first-cycle not floated");
      evaluation_mode <= 1'b0;
      repeat (3) @(posedge clk);
      chk(firstCycleOeN === 1'b0, "first-cycle not driven");
   endtask
   // Hand the bus to an outside master, let it read and write, take it back
   task automatic t_release();
      int n;
      busReleaseReq <= 1'b1;
      for (n = 0; n < 8 && busReleased !== 1'b1; n++) @(posedge clk);
      chk(busReleased === 1'b1, "release timed out");
      if (busReleased !== 1'b1) report_and_stop();
      chk(&{addrLinesOeN, dataLinesOeN, ctrlOeN, memRequestOeN}, "pins driven");
      {extAddr, extRdN, extIoN} <= {16'h00a5, 1'b0, 1'b0};
      repeat (3) @(posedge clk);
      chk(extAddr_ff === 16'h00a5 && {extRead_ff, extIoReq_ff} === 2'b11, "ext read");
      {extRdN, extWrN} <= 2'b10;
      repeat (3) @(posedge clk);
      chk(extWrite_ff === 1'b1 && extRead_ff === 1'b0, "ext write");
      {extWrN, extIoN, busReleaseReq} <= 3'b110;
      for (n = 0; n < 8 && busReleased !== 1'b0; n++) @(posedge clk);
      repeat (2) @(posedge clk);
      chk(busReleased === 1'b0 && addrLinesOeN === 1'b0, "bus not regained");
      if (n >= 8) report_and_stop();
   endtask
   initial begin
      {rst, cycleReq, busReleaseReq, evaluation_mode} = 4'b1000;
      cycleOp = CBI_OP_FETCH;
      {cycleAddr, cycleWrData, refreshAddr} = 40'h0;
      {extAddr, extRdN, extWrN, extIoN} = {16'h5a5a, 3'b111};
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(&{readNOut, writeNOut, memRequestNOut, ioRequestNOut}, "reset strobes");
      chk(addrLinesOeN === 1'b0 && dataLinesOeN === 1'b1, "reset enables");
      t_mem();
      t_io();
      t_eval();
      t_release();
      t_mem();
      report_and_stop();
   end
endmodule // cpu_system_bus_interface_bench
`default_nettype wire
